//--- rtl/ssr_receiver.sv
// Our own choices: register access over AHB-Lite and the register addresses.
module ssr_receiver #(
  parameter int FIFO_DEPTH = ssr_pkg::FIFO_DEPTH
) (
  input  wire logic        ref_clk,         // system clock, 40 MHz
  input  wire logic        srst,            // synchronous reset, active high
  input  wire logic        hsel,            // slave select
  input  wire logic [31:0] haddr,           // byte address
  input  wire logic [1:0]  htrans,          // transfer type
  input  wire logic        hwrite,          // write when high
  input  wire logic [2:0]  hsize,           // transfer size, word only
  input  wire logic [31:0] hwdata,          // write data
  input  wire logic        hready,          // bus ready in
  output logic             hreadyout,       // ready out
  output logic      [31:0] hrdata,          // read data
  output logic             hresp,           // response, always okay
  input  wire logic        serial_clock_pin, // shift clock from master
  input  wire logic        serial_data_pin, // serial data from master
  input  wire logic        sleep_mode,      // core is asleep
  output logic             irq,             // level interrupt
  output logic             core_wake,       // wake request to core
  output logic             int_vector_req   // branch to interrupt vector
);

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int NB = ssr_pkg::NINE_BITS;

  function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
    return a == 32'(ofs);
  endfunction

  // bus side
  logic        hreadyout_r;
  logic [31:0] hrdata_r;
  logic        hresp_r;
  logic        wr_pend_r;
  logic [31:0] wr_addr_r;
  logic        acc;
  logic        wr_data;
  logic [7:0]  wdat;
  logic [7:0]  rd_val;

  // control registers
  logic [7:0]  rx_ctl_r;
  logic [7:0]  tx_ctl_r;
  logic [7:0]  core_ctl_r;
  logic [ssr_pkg::IRQ_BITS-1:0] irq_en_r;
  logic [ssr_pkg::IRQ_BITS-1:0] irq_stat_r;
  logic [ssr_pkg::IRQ_BITS-1:0] irq_evt;
  logic        overrun_error_flag_r;

  // receive path
  ssr_pkg::ssr_state_type state_r;
  logic [1:0]    pin_s;
  logic          ck_s;
  logic          dt_s;
  logic          ck_prev_r;
  logic          clk_fall;
  logic [NB-1:0] sh_r;
  logic [NB-1:0] sh_nxt;
  logic [3:0]    bit_cnt_r;
  logic [3:0]    last_bit;
  logic          slave_rx;
  logic          word_done;
  logic          push;
  logic          pop;
  logic          ovr_evt;
  logic [NB-1:0] word_in;

  // receive queue
  logic [NB-1:0] fifo_mem_r [FIFO_DEPTH];
  logic [PW-1:0] wptr_r;
  logic [PW-1:0] rptr_r;
  logic [CW-1:0] cnt_r;
  logic          fifo_full;
  logic          fifo_empty;
  logic [NB-1:0] head_w;
  logic          any_irq;

  // pins are inputs only; the master owns both lines
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      ssr_sync3 #(.INIT(1'b0)) u_sync (
        .ref_clk (ref_clk),
        .srst    (srst),
        .din     (g == 0 ? serial_data_pin : serial_clock_pin),
        .dout    (pin_s[g])
      );
    end
  endgenerate

  assign dt_s = pin_s[0];
  assign ck_s = pin_s[1];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ck_prev_r <= 1'b0;
    end else begin
      ck_prev_r <= ck_s;
    end
  end

  // data and clock share one synchroniser delay, so sampling stays aligned
  assign clk_fall = ck_prev_r & ~ck_s;

  // single-receive bit deliberately absent from the mode term
  assign slave_rx = rx_ctl_r[ssr_pkg::RXB_SERIAL_PORT_ENABLE]
                  & tx_ctl_r[ssr_pkg::TXB_SYNC]
                  & ~tx_ctl_r[ssr_pkg::TXB_CLOCK_SOURCE_SELECT]
                  & rx_ctl_r[ssr_pkg::RXB_CONTINUOUS_RECEIVE_ENABLE];

  assign last_bit = rx_ctl_r[ssr_pkg::RXB_NINE] ? 4'(NB - 1) : 4'(ssr_pkg::DATA_BITS - 1);

  // lsb first; bits enter at the top of the shift register
  assign sh_nxt  = {dt_s, sh_r[NB-1:1]};
  assign word_in = rx_ctl_r[ssr_pkg::RXB_NINE] ? sh_nxt : {1'b0, sh_nxt[NB-1:1]};

  // sleep_mode is not looked at: the external clock keeps shifting
  assign word_done = (state_r == ssr_pkg::ST_RECV) && slave_rx && clk_fall
                   && (bit_cnt_r == last_bit);

  assign fifo_full  = cnt_r == CW'(FIFO_DEPTH);
  assign fifo_empty = cnt_r == '0;
  assign push       = word_done && !fifo_full;
  assign ovr_evt    = word_done && fifo_full;
  assign head_w     = fifo_mem_r[rptr_r];

  // state machine
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= ssr_pkg::ST_OFF;
    end else begin
      case (state_r)
        ssr_pkg::ST_OFF: begin
          if (slave_rx) begin
            state_r <= ssr_pkg::ST_RECV;
          end
        end
        ssr_pkg::ST_RECV: begin
          if (!slave_rx) begin
            state_r <= ssr_pkg::ST_OFF;
          end else if (ovr_evt) begin
            state_r <= ssr_pkg::ST_HALT;
          end
        end
        ssr_pkg::ST_HALT: begin
          // stays halted until software drops the enable
          if (!slave_rx) begin
            state_r <= ssr_pkg::ST_OFF;
          end
        end
        default: begin
          state_r <= ssr_pkg::ST_OFF;
        end
      endcase
    end
  end

  // shifter
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sh_r      <= '0;
      bit_cnt_r <= '0;
    end else if (state_r != ssr_pkg::ST_RECV || !slave_rx) begin
      bit_cnt_r <= '0;
    end else if (clk_fall) begin
      sh_r      <= sh_nxt;
      bit_cnt_r <= word_done ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      overrun_error_flag_r <= 1'b0;
    end else if (ovr_evt) begin
      overrun_error_flag_r <= 1'b1;
    end else if (!rx_ctl_r[ssr_pkg::RXB_CONTINUOUS_RECEIVE_ENABLE] || !rx_ctl_r[ssr_pkg::RXB_SERIAL_PORT_ENABLE]) begin
      overrun_error_flag_r <= 1'b0;
    end
  end

  // receive queue; dropping port enable flushes it
  always_ff @(posedge ref_clk) begin
    if (srst || !rx_ctl_r[ssr_pkg::RXB_SERIAL_PORT_ENABLE]) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      fifo_mem_r[wptr_r] <= word_in;
    end
  end

  // bus address phase
  assign acc     = hsel && hready && htrans[ssr_pkg::HTRANS_ACT];
  assign pop     = acc && !hwrite && hit(haddr, ssr_pkg::OFS_RX_DATA) && !fifo_empty;
  assign wdat    = hwdata[ssr_pkg::DATA_BITS-1:0];
  assign wr_data = wr_pend_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      wr_pend_r <= acc && hwrite;
      if (acc) begin
        wr_addr_r <= haddr;
      end
    end
  end

  always_comb begin
    rd_val = ssr_pkg::REG_RST;
    if (hit(haddr, ssr_pkg::OFS_RX_STA)) begin
      rd_val = rx_ctl_r;
      rd_val[ssr_pkg::RXB_OVERRUN_ERROR_FLAG] = overrun_error_flag_r;
      rd_val[ssr_pkg::RXB_D9]   = head_w[NB-1] & ~fifo_empty;
    end else if (hit(haddr, ssr_pkg::OFS_RX_DATA)) begin
      rd_val = fifo_empty ? ssr_pkg::REG_RST : head_w[ssr_pkg::DATA_BITS-1:0];
    end else if (hit(haddr, ssr_pkg::OFS_TX_STA)) begin
      rd_val = tx_ctl_r;
    end else if (hit(haddr, ssr_pkg::OFS_CORE_IRQ)) begin
      rd_val = core_ctl_r;
    end else if (hit(haddr, ssr_pkg::OFS_BAUD)) begin
      rd_val[ssr_pkg::BDB_RCIDL] = state_r == ssr_pkg::ST_OFF;
    end else if (hit(haddr, ssr_pkg::OFS_IRQ_STAT)) begin
      rd_val = 8'(irq_stat_r);
    end else if (hit(haddr, ssr_pkg::OFS_IRQ_EN)) begin
      rd_val = 8'(irq_en_r);
    end
  end

  // zero wait states: read data is latched at the address phase edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hrdata_r    <= '0;
      hreadyout_r <= 1'b0;
      hresp_r     <= ssr_pkg::HRESP_OKAY;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r     <= ssr_pkg::HRESP_OKAY;
      if (acc && !hwrite) begin
        hrdata_r <= 32'(rd_val);
      end
    end
  end

  // register writes land in the data phase
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_ctl_r   <= ssr_pkg::REG_RST;
      tx_ctl_r   <= ssr_pkg::REG_RST;
      core_ctl_r <= ssr_pkg::REG_RST;
      irq_en_r   <= '0;
    end else if (wr_data) begin
      if (hit(wr_addr_r, ssr_pkg::OFS_RX_STA)) begin
        rx_ctl_r <= wdat & ssr_pkg::RX_STA_WMASK;
      end else if (hit(wr_addr_r, ssr_pkg::OFS_TX_STA)) begin
        tx_ctl_r <= wdat & ssr_pkg::TX_STA_WMASK;
      end else if (hit(wr_addr_r, ssr_pkg::OFS_CORE_IRQ)) begin
        core_ctl_r <= wdat & ssr_pkg::CORE_WMASK;
      end else if (hit(wr_addr_r, ssr_pkg::OFS_IRQ_EN)) begin
        irq_en_r <= wdat[ssr_pkg::IRQ_BITS-1:0];
      end
    end
  end

  // sticky events; a set in the clearing cycle wins
  assign irq_evt = {ovr_evt, push};

  generate
    for (g = 0; g < ssr_pkg::IRQ_BITS; g++) begin : g_irq
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          irq_stat_r[g] <= 1'b0;
        end else if (irq_evt[g]) begin
          irq_stat_r[g] <= 1'b1;
        end else if (wr_data && hit(wr_addr_r, ssr_pkg::OFS_IRQ_CLR) && wdat[g]) begin
          irq_stat_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign any_irq = |(irq_stat_r & irq_en_r);

  logic irq_r;
  logic core_wake_r;
  logic vector_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_r       <= 1'b0;
      core_wake_r <= 1'b0;
      vector_r    <= 1'b0;
    end else begin
      irq_r       <= any_irq;
      core_wake_r <= any_irq && sleep_mode;
      vector_r    <= any_irq && core_ctl_r[ssr_pkg::INTB_GIE];
    end
  end

  assign hreadyout      = hreadyout_r;
  assign hrdata         = hrdata_r;
  assign hresp          = hresp_r;
  assign irq            = irq_r;
  assign core_wake      = core_wake_r;
  assign int_vector_req = vector_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  a_never_idle: assert property (
    state_r != ssr_pkg::ST_OFF && slave_rx |=> state_r != ssr_pkg::ST_OFF)
    else $error("receiver left slave mode while enabled");

  a_single_receive_enable_ignored: assert property (
    state_r == ssr_pkg::ST_OFF && slave_rx
    |=> state_r == ssr_pkg::ST_RECV)
    else $error("reception depends on single-receive bit");

  a_start_recv: assert property (
    state_r == ssr_pkg::ST_RECV |-> $past(rx_ctl_r[ssr_pkg::RXB_CONTINUOUS_RECEIVE_ENABLE]))
    else $error("receiving without continuous receive");

  a_mode_gate: assert property (
    !slave_rx |=> state_r == ssr_pkg::ST_OFF)
    else $error("receiver active outside slave mode");

  a_push_word: assert property (
    push && !pop |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("completed word not queued");

  a_rx_flag: assert property (
    push |=> irq_stat_r[ssr_pkg::IRQB_RX] ##1 (irq_r || !irq_en_r[ssr_pkg::IRQB_RX]))
    else $error("receive flag or interrupt missing");

  a_wake_core: assert property (
    any_irq && sleep_mode |=> core_wake_r)
    else $error("no wake on enabled interrupt in sleep");

  a_vector_req: assert property (
    $rose(irq_r) && core_ctl_r[ssr_pkg::INTB_GIE] && $past(core_ctl_r[ssr_pkg::INTB_GIE])
    |-> vector_r)
    else $error("no vector request with global enable");

  a_ovr_set: assert property (
    ovr_evt && !pop |=> overrun_error_flag_r && state_r == ssr_pkg::ST_HALT && cnt_r == CW'(FIFO_DEPTH))
    else $error("overrun not flagged or queue changed");

  a_ovr_clear: assert property (
    overrun_error_flag_r && !rx_ctl_r[ssr_pkg::RXB_CONTINUOUS_RECEIVE_ENABLE] |=> !overrun_error_flag_r [*2])
    else $error("overrun not cleared by enable drop");

  c_word: cover property (push);
  c_overrun: cover property (ovr_evt);
  c_wake: cover property (sleep_mode && push ##2 core_wake_r);
  c_nine: cover property (push && rx_ctl_r[ssr_pkg::RXB_NINE] && word_in[NB-1]);

endmodule

//--- shared/ssr_pkg.sv
package ssr_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_RX_STA   = 8'h00;
  localparam logic [7:0] OFS_RX_DATA  = 8'h04;
  localparam logic [7:0] OFS_TX_STA   = 8'h08;
  localparam logic [7:0] OFS_CORE_IRQ = 8'h0c;
  localparam logic [7:0] OFS_BAUD     = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h1c;

  // rx_status_control fields
  localparam int RXB_SERIAL_PORT_ENABLE  = 7;
  localparam int RXB_NINE  = 6;
  localparam int RXB_SINGLE_RECEIVE_ENABLE  = 5;
  localparam int RXB_CONTINUOUS_RECEIVE_ENABLE  = 4;
  localparam int RXB_OVERRUN_ERROR_FLAG  = 1;
  localparam int RXB_D9    = 0;

  // tx_status_control, core_interrupt_control, baud_control fields
  localparam int TXB_CLOCK_SOURCE_SELECT  = 7;
  localparam int TXB_SYNC  = 4;
  localparam int INTB_GIE  = 7;
  localparam int BDB_RCIDL = 6;

  // interrupt status / clear / enable layout
  localparam int IRQB_RX   = 0;
  localparam int IRQB_OVR  = 1;
  localparam int IRQ_BITS  = 2;

  localparam logic [7:0] RX_STA_WMASK = 8'hf8;
  localparam logic [7:0] TX_STA_WMASK = 8'hfc;
  localparam logic [7:0] CORE_WMASK   = 8'hc0;
  localparam logic [7:0] REG_RST      = 8'h00;

  localparam int DATA_BITS  = 8;
  localparam int NINE_BITS  = 9;
  localparam int FIFO_DEPTH = 2;
  localparam int HTRANS_ACT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_RECV = 2'b01,
    ST_HALT = 2'b10
  } ssr_state_type;

endpackage

//--- rtl/ssr_sync3.sv
module ssr_sync3 #(
  parameter logic INIT = 1'b0
) (
  input  wire logic ref_clk, // system clock
  input  wire logic srst,    // synchronous reset
  input  wire logic din,     // asynchronous pin level
  output logic      dout     // filtered level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic out_r;

  // a change is taken only once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1_r  <= INIT;
      s2_r  <= INIT;
      s3_r  <= INIT;
      out_r <= INIT;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        out_r <= s3_r;
      end
    end
  end

  assign dout = out_r;

endmodule

//--- verification/ssr_link_master.sv
// far-side synchronous master: drives shift clock and data, both pins are inputs at the block
module ssr_link_master (
  output logic sclk,  // shift clock, idle low between frames
  output logic sdata  // serial data, lsb first
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk  = 1'b0;
    sdata = 1'b1;
  end

  // half sets the pace: 100 gives the 200 ns period, larger values model a slow master
  task automatic send(input logic [8:0] w, input int n, input int half);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      #10;
      sdata = w[i];
      #(half - 10);
      sclk = 1'b0;
      #half;
    end
    // released line: show the inverse so a late sample cannot pass by luck
    sdata = ~sdata;
  endtask
endmodule

//--- verification/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk    = 1'b0;
  logic        srst       = 1'b1;
  logic        hsel       = 1'b0;
  logic [31:0] haddr      = 32'h0;
  logic [1:0]  htrans     = 2'h0;
  logic        hwrite     = 1'b0;
  logic [2:0]  hsize      = 3'h2;
  logic [31:0] hwdata     = 32'h0;
  logic        sleep_mode = 1'b0;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic        core_wake;
  logic        int_vector_req;
  logic        sclk;
  logic        sdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  int          mismatches = 0;
  int          n_compared = 0;

  always #12.5 ref_clk = ~ref_clk;

  ssr_receiver dut (
    .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .serial_clock_pin(sclk), .serial_data_pin(sdata), .sleep_mode(sleep_mode),
    .irq(irq), .core_wake(core_wake), .int_vector_req(int_vector_req)
  );

  ssr_link_master mst (
    .sclk(sclk),
    .sdata(sdata)
  );

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // bounded wait for hready; a hang ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    if (hreadyout !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t bus wait ran out", $time);
      finish_test();
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd & mask, exp);
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 80) begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    if (irq !== 1'b1) begin
      finish_test();
    end
  endtask

  task automatic t_reset;
    rdc(ssr_pkg::OFS_RX_STA, 32'hffffffff, 32'h0);
    rdc(ssr_pkg::OFS_TX_STA, 32'hffffffff, 32'h0);
    rdc(ssr_pkg::OFS_IRQ_STAT, 32'hffffffff, 32'h0);
    rdc(8'h40, 32'hffffffff, 32'h0);
    rdc(ssr_pkg::OFS_BAUD, 32'h40, 32'h40);
  endtask

  // reception refused when the clock is not external or continuous receive is off
  task automatic t_gate;
    wr(ssr_pkg::OFS_IRQ_EN, 32'h1);
    wr(ssr_pkg::OFS_TX_STA, 32'h90);
    wr(ssr_pkg::OFS_RX_STA, 32'h90);
    mst.send(9'h05a, 8, 100);
    cyc(20);
    rdc(ssr_pkg::OFS_IRQ_STAT, 32'h3, 32'h0);
    wr(ssr_pkg::OFS_TX_STA, 32'h10);
    wr(ssr_pkg::OFS_RX_STA, 32'h80);
    mst.send(9'h05a, 8, 100);
    cyc(20);
    rdc(ssr_pkg::OFS_IRQ_STAT, 32'h3, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  // single-receive bit set on purpose: it must not matter
  task automatic t_sleep;
    wr(ssr_pkg::OFS_RX_STA, 32'hb0);
    sleep_mode <= 1'b1;
    rdc(ssr_pkg::OFS_BAUD, 32'h40, 32'h0);
    mst.send(9'h0a5, 8, 100);
    wait_irq();
    cyc(2);
    chk({31'h0, core_wake}, 32'h1);
    chk({31'h0, int_vector_req}, 32'h0);
    wr(ssr_pkg::OFS_CORE_IRQ, 32'h80);
    cyc(2);
    chk({31'h0, int_vector_req}, 32'h1);
    rdc(ssr_pkg::OFS_RX_DATA, 32'hffffffff, 32'ha5);
    wr(ssr_pkg::OFS_IRQ_CLR, 32'h1);
    rdc(ssr_pkg::OFS_IRQ_STAT, 32'h3, 32'h0);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    sleep_mode <= 1'b0;
    wr(ssr_pkg::OFS_CORE_IRQ, 32'h0);
  endtask

  task automatic t_nine;
    wr(ssr_pkg::OFS_CORE_IRQ, 32'h80);
    wr(ssr_pkg::OFS_RX_STA, 32'hd0);
    mst.send(9'h13c, 9, 100);
    wait_irq();
    cyc(1);
    chk({31'h0, core_wake}, 32'h0);
    chk({31'h0, int_vector_req}, 32'h1);
    rdc(ssr_pkg::OFS_RX_STA, 32'h1, 32'h1);
    rdc(ssr_pkg::OFS_RX_DATA, 32'hffffffff, 32'h3c);
    wr(ssr_pkg::OFS_IRQ_CLR, 32'h3);
    wr(ssr_pkg::OFS_CORE_IRQ, 32'h0);
  endtask

  // third word finds the two-entry queue full; later words stay out until the error clears
  task automatic t_ovr;
    wr(ssr_pkg::OFS_RX_STA, 32'h90);
    mst.send(9'h011, 8, 100);
    mst.send(9'h022, 8, 100);
    mst.send(9'h033, 8, 100);
    cyc(20);
    rdc(ssr_pkg::OFS_RX_STA, 32'h2, 32'h2);
    rdc(ssr_pkg::OFS_IRQ_STAT, 32'h2, 32'h2);
    mst.send(9'h044, 8, 100);
    cyc(20);
    rdc(ssr_pkg::OFS_RX_DATA, 32'hffffffff, 32'h11);
    rdc(ssr_pkg::OFS_RX_DATA, 32'hffffffff, 32'h22);
    rdc(ssr_pkg::OFS_RX_DATA, 32'hffffffff, 32'h0);
    wr(ssr_pkg::OFS_RX_STA, 32'h80);
    rdc(ssr_pkg::OFS_RX_STA, 32'h2, 32'h0);
    // second overrun, this time cleared by dropping port enable, which also flushes the queue
    wr(ssr_pkg::OFS_RX_STA, 32'h90);
    mst.send(9'h055, 8, 100);
    mst.send(9'h066, 8, 100);
    mst.send(9'h077, 8, 100);
    cyc(20);
    rdc(ssr_pkg::OFS_RX_STA, 32'h2, 32'h2);
    wr(ssr_pkg::OFS_RX_STA, 32'h10);
    rdc(ssr_pkg::OFS_RX_STA, 32'h2, 32'h0);
    rdc(ssr_pkg::OFS_RX_DATA, 32'hffffffff, 32'h0);
  endtask

  initial begin
    cyc(2);
    srst <= 1'b0;
    cyc(2);
    t_reset();
    t_gate();
    t_sleep();
    t_nine();
    t_ovr();
    finish_test();
  end
endmodule
